// File: rtl/aotb_pkg.sv
// Package: constants for the converter trim register bank.
// Assumes byte addresses on a plain strobe port, one register per address.
package aotb_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int OFS_W = 12;
    localparam int GAIN_W = 5;
    localparam int GAIN_REG_W = 8;
    // ========================================
    // Register offsets
    localparam logic [11:0] ADDR_A_OFS_IN2_P90 = 12'h34a;
    localparam logic [11:0] ADDR_B_OFS_IN1 = 12'h34c;
    localparam logic [11:0] ADDR_B_OFS_IN2 = 12'h34e;
    localparam logic [11:0] ADDR_A_BANK0_GAIN = 12'h350;
    localparam logic [11:0] ADDR_A_BANK1_GAIN = 12'h351;
    localparam logic [11:0] ADDR_B_BANK0_GAIN = 12'h352;
    localparam logic [11:0] ADDR_B_BANK1_GAIN = 12'h353;
    // ========================================
    // Reset and field values
    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [11:0] OFS_ZERO = 12'h000;
    localparam logic [4:0] GAIN_ZERO = 5'h00;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
    localparam logic [7:0] GAIN_FIELD_MASK = 8'h1f;
    // ========================================
    // Fuse load slot numbering
    localparam int NUM_SLOTS = 7;
    localparam logic [2:0] SLOT_A_OFS = 3'h0;
    localparam logic [2:0] SLOT_B_OFS1 = 3'h1;
    localparam logic [2:0] SLOT_B_OFS2 = 3'h2;
    localparam logic [2:0] SLOT_A_G0 = 3'h3;
    localparam logic [2:0] SLOT_A_G1 = 3'h4;
    localparam logic [2:0] SLOT_B_G0 = 3'h5;
    localparam logic [2:0] SLOT_B_G1 = 3'h6;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_STEP = 3'h1;

    typedef enum logic [1:0] {
        AOTB_LD_IDLE,
        AOTB_LD_RUN,
        AOTB_LD_DONE
    } aotb_load_state_t;
endpackage

// File: rtl/aotb_fuse_loader.sv
// Fuse loader: walks the trim slots once after reset and asks the fuse store
// for each. Assumes the fuse store answers in the cycle after the request.
`timescale 1ns/1ns
module aotb_fuse_loader (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    output logic fuse_req, // Fuse read request
    output logic [2:0] fuse_slot, // Slot being read
    input wire logic [15:0] fuse_data, // Fuse word, one cycle after request
    output logic load_we, // Load strobe toward the bank
    output logic [2:0] load_slot, // Slot to load
    output logic [15:0] load_data, // Value to load
    output logic load_done // All defaults loaded
);
    aotb_pkg::aotb_load_state_t state_reg;
    logic [2:0] slot_reg;

    // ========================================
    // Slot walk
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= aotb_pkg::AOTB_LD_IDLE;
            slot_reg <= aotb_pkg::SLOT_FIRST;
        end else begin
            unique case (state_reg)
                aotb_pkg::AOTB_LD_IDLE: begin
                    state_reg <= aotb_pkg::AOTB_LD_RUN;
                end
                aotb_pkg::AOTB_LD_RUN: begin
                    if (slot_reg == aotb_pkg::SLOT_LAST) begin
                        state_reg <= aotb_pkg::AOTB_LD_DONE;
                    end else begin
                        slot_reg <= slot_reg + aotb_pkg::SLOT_STEP;
                    end
                end
                aotb_pkg::AOTB_LD_DONE: begin
                    state_reg <= aotb_pkg::AOTB_LD_DONE;
                end
                default: begin
                    state_reg <= aotb_pkg::AOTB_LD_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Request now, write the answer one cycle later
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fuse_req <= 1'b0;
            fuse_slot <= aotb_pkg::SLOT_FIRST;
            load_we <= 1'b0;
            load_slot <= aotb_pkg::SLOT_FIRST;
            load_done <= 1'b0;
        end else begin
            fuse_req <= (state_reg == aotb_pkg::AOTB_LD_RUN);
            fuse_slot <= slot_reg;
            load_we <= fuse_req;
            load_slot <= fuse_slot;
            load_done <= (state_reg == aotb_pkg::AOTB_LD_DONE) && !fuse_req && !load_we;
        end
    end

    assign load_data = fuse_data;
endmodule

// File: rtl/aotb_trim_bank.sv
// Trim register bank for two converter cores: offset and fine-gain
// corrections, defaults from fuses, selection of the applied value.
// Assumes the configuration port gives one-cycle strobes, never both at once.
//
// How it works
// RQ1 - Core A offset, second input, phase 90
// RQ2 - Core B offset when sampling first input
// RQ3 - Core B offset, second input, both modes
// RQ4 - Core A bank 0 gain, bits 4:0
// RQ5 - Core B bank 0 and 1 gains
// RQ6 - Core A bank 1 gain, upper bits reserved
// RQ7 - Reads zero reset, then fuse defaults load
// RQ8 - Offset registers 16 bits, nibble reserved
// RQ9 - Mode, input, phase select applied trims
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module aotb_trim_bank (
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [11:0] cfg_addr, // Register byte address
    input wire logic [15:0] cfg_wdata, // Write data
    input wire logic cfg_wr, // Write strobe
    input wire logic cfg_rd, // Read strobe
    output logic [15:0] cfg_rdata, // Read data, cycle after strobe
    output logic fuse_req, // Fuse read request
    output logic [2:0] fuse_slot, // Fuse slot address
    input wire logic [15:0] fuse_data, // Fuse word, cycle after request
    input wire logic fg_cal_en, // Foreground calibration enabled
    input wire logic single_mode, // 1 single channel, 0 dual channel
    input wire logic core_a_in2, // Core A samples the second input
    input wire logic core_a_phase90, // Core A on 90 degree phase
    input wire logic core_b_in2, // Core B samples the second input
    input wire logic gain_bank, // Bank of the current sample
    output logic [11:0] core_a_offset, // Applied core A offset
    output logic core_a_offset_valid, // Core A offset is from this bank
    output logic [11:0] core_b_offset, // Applied core B offset
    output logic [4:0] core_a_gain, // Applied core A fine gain
    output logic [4:0] core_b_gain, // Applied core B fine gain
    output logic defaults_loaded // Fuse defaults are in place
);
    logic [15:0] a_ofs_reg;
    logic [15:0] b_ofs1_reg;
    logic [15:0] b_ofs2_reg;
    logic [7:0] gain_reg [4];
    logic load_we;
    logic [2:0] load_slot;
    logic [15:0] load_data;
    logic load_done;
    logic [2:0] wr_slot;
    logic wr_hit;

    // ========================================
    // Address decode, shared by reads and writes
    function automatic logic [3:0] decode(input logic [11:0] addr);
        unique case (addr)
            aotb_pkg::ADDR_A_OFS_IN2_P90: decode = {1'b1, aotb_pkg::SLOT_A_OFS};
            aotb_pkg::ADDR_B_OFS_IN1: decode = {1'b1, aotb_pkg::SLOT_B_OFS1};
            aotb_pkg::ADDR_B_OFS_IN2: decode = {1'b1, aotb_pkg::SLOT_B_OFS2};
            aotb_pkg::ADDR_A_BANK0_GAIN: decode = {1'b1, aotb_pkg::SLOT_A_G0};
            aotb_pkg::ADDR_A_BANK1_GAIN: decode = {1'b1, aotb_pkg::SLOT_A_G1};
            aotb_pkg::ADDR_B_BANK0_GAIN: decode = {1'b1, aotb_pkg::SLOT_B_G0};
            aotb_pkg::ADDR_B_BANK1_GAIN: decode = {1'b1, aotb_pkg::SLOT_B_G1};
            default: decode = {1'b0, aotb_pkg::SLOT_FIRST};
        endcase
    endfunction

    assign {wr_hit, wr_slot} = decode(cfg_addr);

    // ========================================
    // Fuse default loader
    // RQ7 fuse default load
    aotb_fuse_loader u_loader (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .fuse_req(fuse_req),
        .fuse_slot(fuse_slot),
        .fuse_data(fuse_data),
        .load_we(load_we),
        .load_slot(load_slot),
        .load_data(load_data),
        .load_done(load_done)
    );

    // ========================================
    // Offset registers
    // RQ8 full 16-bit storage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // RQ7 printed zero reset
            a_ofs_reg <= aotb_pkg::OFS_RESET;
            b_ofs1_reg <= aotb_pkg::OFS_RESET;
            b_ofs2_reg <= aotb_pkg::OFS_RESET;
        end else begin
            // Write wins over a fuse load only for the register it hits
            // RQ1 core A register
            if (cfg_wr && wr_hit && wr_slot == aotb_pkg::SLOT_A_OFS) begin
                a_ofs_reg <= cfg_wdata;
            end else if (load_we && load_slot == aotb_pkg::SLOT_A_OFS) begin
                a_ofs_reg <= load_data;
            end
            // RQ2 core B input one
            if (cfg_wr && wr_hit && wr_slot == aotb_pkg::SLOT_B_OFS1) begin
                b_ofs1_reg <= cfg_wdata;
            end else if (load_we && load_slot == aotb_pkg::SLOT_B_OFS1) begin
                b_ofs1_reg <= load_data;
            end
            // RQ3 core B input two
            if (cfg_wr && wr_hit && wr_slot == aotb_pkg::SLOT_B_OFS2) begin
                b_ofs2_reg <= cfg_wdata;
            end else if (load_we && load_slot == aotb_pkg::SLOT_B_OFS2) begin
                b_ofs2_reg <= load_data;
            end
        end
    end

    // ========================================
    // Fine-gain registers, 8 bits each, all bits stored
    // RQ4 RQ5 RQ6 gain storage
    for (genvar g = 0; g < 4; g++) begin : g_gain
        localparam logic [2:0] SLOT = 3'(g) + aotb_pkg::SLOT_A_G0;
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                gain_reg[g] <= aotb_pkg::GAIN_RESET;
            end else if (cfg_wr && wr_hit && wr_slot == SLOT) begin
                gain_reg[g] <= cfg_wdata[7:0];
            end else if (load_we && load_slot == SLOT) begin
                gain_reg[g] <= load_data[7:0];
            end
        end
    end

    // ========================================
    // Read port, data valid the cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_rdata <= aotb_pkg::RD_UNMAPPED;
        end else if (cfg_rd) begin
            unique case (decode(cfg_addr))
                {1'b1, aotb_pkg::SLOT_A_OFS}: cfg_rdata <= a_ofs_reg;
                {1'b1, aotb_pkg::SLOT_B_OFS1}: cfg_rdata <= b_ofs1_reg;
                {1'b1, aotb_pkg::SLOT_B_OFS2}: cfg_rdata <= b_ofs2_reg;
                {1'b1, aotb_pkg::SLOT_A_G0}: cfg_rdata <= {8'h00, gain_reg[0]};
                {1'b1, aotb_pkg::SLOT_A_G1}: cfg_rdata <= {8'h00, gain_reg[1]};
                {1'b1, aotb_pkg::SLOT_B_G0}: cfg_rdata <= {8'h00, gain_reg[2]};
                {1'b1, aotb_pkg::SLOT_B_G1}: cfg_rdata <= {8'h00, gain_reg[3]};
                default: cfg_rdata <= aotb_pkg::RD_UNMAPPED;
            endcase
        end else begin
            cfg_rdata <= aotb_pkg::RD_UNMAPPED;
        end
    end

    // ========================================
    // Correction selection, registered; new values apply next sample
    // RQ9 select by mode
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            core_a_offset <= aotb_pkg::OFS_ZERO;
            core_a_offset_valid <= 1'b0;
            core_b_offset <= aotb_pkg::OFS_ZERO;
        end else begin
            // RQ1 single mode phase 90
            if (fg_cal_en && single_mode && core_a_in2 && core_a_phase90) begin
                core_a_offset <= a_ofs_reg[aotb_pkg::OFS_W-1:0];
                core_a_offset_valid <= 1'b1;
            end else begin
                core_a_offset <= aotb_pkg::OFS_ZERO;
                core_a_offset_valid <= 1'b0;
            end
            // RQ2 RQ3 core B input select
            if (!fg_cal_en) begin
                core_b_offset <= aotb_pkg::OFS_ZERO;
            end else if (core_b_in2) begin
                core_b_offset <= b_ofs2_reg[aotb_pkg::OFS_W-1:0];
            end else begin
                core_b_offset <= b_ofs1_reg[aotb_pkg::OFS_W-1:0];
            end
        end
    end

    // RQ4 RQ5 RQ6 dual mode gains
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            core_a_gain <= aotb_pkg::GAIN_ZERO;
            core_b_gain <= aotb_pkg::GAIN_ZERO;
        end else if (fg_cal_en && !single_mode) begin
            core_a_gain <= gain_bank ? gain_reg[1][aotb_pkg::GAIN_W-1:0] : gain_reg[0][aotb_pkg::GAIN_W-1:0];
            core_b_gain <= gain_bank ? gain_reg[3][aotb_pkg::GAIN_W-1:0] : gain_reg[2][aotb_pkg::GAIN_W-1:0];
        end else begin
            core_a_gain <= aotb_pkg::GAIN_ZERO;
            core_b_gain <= aotb_pkg::GAIN_ZERO;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            defaults_loaded <= 1'b0;
        end else begin
            defaults_loaded <= load_done;
        end
    end
endmodule

// File: testbench/aotb_trim_bank_assertions.sv
// Checker: port-level relations of the trim register bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ns
module aotb_trim_bank_chk (
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire logic [11:0] cfg_addr, // address
    input wire logic [15:0] cfg_wdata, // write data
    input wire logic cfg_wr, // write strobe
    input wire logic cfg_rd, // read strobe
    input wire logic [15:0] cfg_rdata, // read data
    input wire logic fuse_req, // fuse request
    input wire logic [2:0] fuse_slot, // fuse slot
    input wire logic fg_cal_en, // calibration on
    input wire logic single_mode, // single channel
    input wire logic core_a_in2, // core A input
    input wire logic core_a_phase90, // core A phase
    input wire logic [11:0] core_a_offset, // core A offset
    input wire logic core_a_offset_valid, // core A valid
    input wire logic [11:0] core_b_offset, // core B offset
    input wire logic [4:0] core_a_gain, // core A gain
    input wire logic [4:0] core_b_gain, // core B gain
    input wire logic defaults_loaded // defaults in place
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ========================================
    // Register port
    a_rdata_idle: assert property (cfg_rdata != 16'h0000 |-> $past(cfg_rd))
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (cfg_rd && !(cfg_addr inside {12'h34a, 12'h34c, 12'h34e, [12'h350:12'h353]})
        |=> cfg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_gain_upper_zero: assert property (cfg_rd && cfg_addr inside {[12'h350:12'h353]} |=> cfg_rdata[15:8] == 8'h00)
        else $error("gain read upper byte set");
    a_write_readback: assert property ((cfg_wr && cfg_addr == 12'h34c && defaults_loaded) ##1 !cfg_wr
        ##1 (cfg_rd && cfg_addr == 12'h34c) |=> cfg_rdata == $past(cfg_wdata, 3)) else $error("readback differs");
    // ========================================
    // Applied trims
    a_a_offset_gate: assert property (!core_a_offset_valid |-> core_a_offset == 12'h000)
        else $error("core A offset without valid");
    a_a_valid_cond: assert property (fg_cal_en && single_mode && core_a_in2 && core_a_phase90 |=> core_a_offset_valid)
        else $error("core A offset not applied");
    a_b_offset_off: assert property (!fg_cal_en |=> core_b_offset == 12'h000)
        else $error("core B offset applied while off");
    a_gain_dual_only: assert property (single_mode || !fg_cal_en |=> core_a_gain == 5'h00 && core_b_gain == 5'h00)
        else $error("gain applied outside dual mode");
    // ========================================
    // Fuse defaults
    a_fuse_walk: assert property (fuse_req && fuse_slot != 3'h6 |=> fuse_req && fuse_slot == 3'($past(fuse_slot) + 3'h1))
        else $error("fuse slots not consecutive");
    a_defaults_time: assert property ($fell(sys_rst) |-> ##[1:20] defaults_loaded)
        else $error("defaults not loaded in time");
    a_defaults_hold: assert property (defaults_loaded |=> defaults_loaded)
        else $error("defaults flag dropped");
endmodule
bind aotb_trim_bank aotb_trim_bank_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .fuse_req(fuse_req),
    .fuse_slot(fuse_slot), .fg_cal_en(fg_cal_en), .single_mode(single_mode), .core_a_in2(core_a_in2),
    .core_a_phase90(core_a_phase90), .core_a_offset(core_a_offset), .core_a_offset_valid(core_a_offset_valid),
    .core_b_offset(core_b_offset), .core_a_gain(core_a_gain), .core_b_gain(core_b_gain),
    .defaults_loaded(defaults_loaded));

// File: testbench/aotb_trim_bank_tb_top.sv
// Testbench: register access, fuse defaults and trim selection of the bank.
// Assumes the bench answers fuse requests from its own table one cycle later.
`timescale 1ns/1ns
module aotb_trim_bank_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] cfg_addr = 12'h000;
    logic [15:0] cfg_wdata = 16'h0000;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [15:0] fuse_data = 16'h0000;
    logic [5:0] mode = 6'h00; // calibration, single, a_in2, phase90, b_in2, bank
    logic [15:0] cfg_rdata;
    logic fuse_req, a_val, done;
    logic [2:0] fuse_slot;
    logic [11:0] a_ofs, b_ofs;
    logic [4:0] a_gain, b_gain;
    logic [15:0] fuse_tab [7];
    logic [15:0] mdl [7];
    logic [11:0] map [7] = '{12'h34a, 12'h34c, 12'h34e, 12'h350, 12'h351, 12'h352, 12'h353};
    logic [31:0] rng = 32'h8faf;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;

    aotb_trim_bank DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .fuse_req(fuse_req), .fuse_slot(fuse_slot),
        .fuse_data(fuse_data), .fg_cal_en(mode[5]), .single_mode(mode[4]), .core_a_in2(mode[3]),
        .core_a_phase90(mode[2]), .core_b_in2(mode[1]), .gain_bank(mode[0]), .core_a_offset(a_ofs),
        .core_a_offset_valid(a_val), .core_b_offset(b_ofs), .core_a_gain(a_gain), .core_b_gain(b_gain),
        .defaults_loaded(done));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One register cycle; a read is compared in the cycle after its strobe
    task automatic acc(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(posedge clk_sys);
        cfg_wr <= wr;
        cfg_rd <= !wr;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        if (!wr) check(cfg_rdata, exp);
    endtask

    task automatic sel_check();
        logic a_hit;
        logic dual;
        a_hit = mode[5] & mode[4] & mode[3] & mode[2];
        dual = mode[5] & !mode[4];
        check({4'h0, a_ofs}, a_hit ? {4'h0, mdl[0][11:0]} : 16'h0000);
        check({15'h0000, a_val}, {15'h0000, a_hit});
        check({4'h0, b_ofs}, mode[5] ? {4'h0, mdl[mode[1] ? 2 : 1][11:0]} : 16'h0000);
        check({11'h000, a_gain}, dual ? {11'h000, mdl[mode[0] ? 4 : 3][4:0]} : 16'h0000);
        check({11'h000, b_gain}, dual ? {11'h000, mdl[mode[0] ? 6 : 5][4:0]} : 16'h0000);
    endtask

    // Fuse store answers one cycle after each request, else shows a changing pattern
    always @(posedge clk_sys) begin
        fuse_data <= (fuse_req === 1'b1) ? fuse_tab[fuse_slot] : ~fuse_data;
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        for (int k = 0; k < 7; k++) begin
            rng = lfsr(rng);
            fuse_tab[k] = rng[15:0];
            mdl[k] = k < 3 ? rng[15:0] : {8'h00, rng[7:0]};
        end
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        acc(1'b0, 12'h353, 16'h0000, 16'h0000);
        for (int w = 0; w < 40 && done !== 1'b1; w++) @(posedge clk_sys);
        check({15'h0000, done}, 16'h0001);
        for (int k = 0; k < 7; k++) acc(1'b0, map[k], 16'h0000, mdl[k]);
        $display("test fuse defaults done");
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 7; k++) begin
                rng = lfsr(rng);
                acc(1'b1, map[k], r == 0 ? 16'hffff : rng[15:0], 16'h0000);
                mdl[k] = k < 3 ? cfg_wdata : {8'h00, cfg_wdata[7:0]};
                acc(1'b0, map[k], 16'h0000, mdl[k]);
            end
            acc(1'b1, 12'h34b, 16'hffff, 16'h0000);
            acc(1'b0, 12'h34b, 16'h0000, 16'h0000);
            acc(1'b0, 12'h354, 16'h0000, 16'h0000);
            acc(1'b0, map[0], 16'h0000, mdl[0]);
            for (int i = 0; i < 64; i++) begin
                @(posedge clk_sys);
                mode <= i[5:0];
                repeat (2) @(posedge clk_sys);
                #1;
                sel_check();
            end
            $display("test round %0d done", r);
        end
        end_of_test();
    end
endmodule
